// [cmbse_exec.sv]
// Function
// - Test: AND self, Z N V S, one cycle
// - Clear: XOR self to zero, Z N V S
// - Multiplies write R1:R0, Z C, two cycles
// - Fractional multiplies shift product left once
// - Relative jump: PC plus offset plus one
// - Pointer jump from Z; absolute jump three cycles
// - Calls: relative/pointer three, absolute four cycles
// - Compare-skip on equal, skips next instruction
// - Compares subtract, discard result, set six flags
// - Register bit skips on clear or set
// - I/O bit skips on set or clear
// - Generic branch on selected status bit
// - Taken branch: offset, two cycles; else one
// - Equal branches test the zero flag
// - Carry and lower/higher branches test carry
// - Signed branches test N xor V; sign branches N
// - Half-carry branches test H flag
// - Transfer branches test T flag
`timescale 1ns/1ps
`default_nettype none

module cmbse_exec (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      arst_n,
	// Instruction issue from the decoder
	input  wire logic                      issue,
	input  wire cmbse_pkg::cmbse_issue_t   issue_data,
	// Flag load from the rest of the core
	input  wire logic                      status_wr,
	input  wire logic [7:0]                status_wdata,
	// Stack pop data, valid in the cycle pop is high
	input  wire logic [15:0]               stack_data,
	// Execution state
	output logic                           busy,
	output logic                           done,
	output logic [15:0]                    pc,
	output logic [7:0]                     status_flags_register,
	// Register file write-back
	output logic                           rd_we,
	output logic [7:0]                     rd_wdata,
	output logic                           pair_we,
	output logic [15:0]                    pair_wdata,
	// Stack requests
	output logic                           push,
	output logic [15:0]                    push_data,
	output logic                           pop
);

	cmbse_pkg::cmbse_state_t s_ff;
	cmbse_pkg::cmbse_state_t nxt_s;

	// Next state of the whole unit
	always_comb begin
		logic [8:0]                      ma;
		logic [8:0]                      mb;
		logic signed [17:0]              prod;
		logic [15:0]                     p16;
		logic [15:0]                     res16;
		logic [7:0]                      sb;
		logic                            cin;
		logic [8:0]                      diff;
		logic [7:0]                      r;
		logic [7:0]                      f;
		logic                            take;
		logic                            skip;
		logic [2:0]                      bsel;
		logic                            bpol;
		logic [cmbse_pkg::PC_W-1:0]      seq;
		logic [cmbse_pkg::PC_W-1:0]      rel;
		logic [cmbse_pkg::PC_W-1:0]      npc;
		logic [cmbse_pkg::CYC_W-1:0]     cost;
		cmbse_pkg::cmbse_wb_t            wb;
		logic                            do_push;
		logic [cmbse_pkg::PC_W-1:0]      rtn_addr;
		logic                            do_pop;
		cmbse_pkg::cmbse_issue_t         i;

		i        = issue_data;
		ma       = 9'h000;
		mb       = 9'h000;
		prod     = 18'sh00000;
		p16      = 16'h0000;
		res16    = 16'h0000;
		sb       = 8'h00;
		cin      = 1'b0;
		diff     = 9'h000;
		r        = 8'h00;
		f        = s_ff.status;
		take     = 1'b0;
		skip     = 1'b0;
		bsel     = i.bit_sel;
		bpol     = 1'b1;
		seq      = s_ff.pc + cmbse_pkg::STEP_1;
		rel      = s_ff.pc + {{(cmbse_pkg::PC_W-cmbse_pkg::OFS_W){i.ofs[cmbse_pkg::OFS_W-1]}},
			i.ofs} + cmbse_pkg::STEP_1;
		npc      = seq;
		cost     = cmbse_pkg::CYC_1;
		wb       = '0;
		do_push  = 1'b0;
		rtn_addr = seq;
		do_pop   = 1'b0;

		nxt_s      = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.push = 1'b0;
		nxt_s.pop  = 1'b0;
		nxt_s.wb   = '0;

		// Operand signedness for the multiplier
		unique case (i.op)
			cmbse_pkg::signed_product, cmbse_pkg::fractional_signed_product: begin
				ma = {i.rd_val[7], i.rd_val};
				mb = {i.rr_val[7], i.rr_val};
			end
			cmbse_pkg::signed_by_unsigned_product, cmbse_pkg::fractional_mixed_product: begin
				ma = {i.rd_val[7], i.rd_val};
				mb = {1'b0, i.rr_val};
			end
			default: begin
				ma = {1'b0, i.rd_val};
				mb = {1'b0, i.rr_val};
			end
		endcase
		prod = $signed(ma) * $signed(mb);
		p16  = prod[15:0];

		// Compare subtractor, shared by all three compares
		sb   = (i.op == cmbse_pkg::compare_immediate) ? i.imm : i.rr_val;
		cin  = (i.op == cmbse_pkg::compare_with_borrow) ? s_ff.status[cmbse_pkg::SB_C] : 1'b0;
		diff = {1'b0, i.rd_val} - {1'b0, sb} - {8'h00, cin};
		r    = diff[7:0];

		// Branch bit and polarity selection
		unique case (i.op)
			cmbse_pkg::branch_on_equal:          begin bsel = cmbse_pkg::SB_Z; bpol = 1'b1; end
			cmbse_pkg::branch_on_unequal:        begin bsel = cmbse_pkg::SB_Z; bpol = 1'b0; end
			cmbse_pkg::branch_carry_one,
			cmbse_pkg::branch_lower:             begin bsel = cmbse_pkg::SB_C; bpol = 1'b1; end
			cmbse_pkg::branch_carry_zero,
			cmbse_pkg::branch_same_or_higher:    begin bsel = cmbse_pkg::SB_C; bpol = 1'b0; end
			cmbse_pkg::branch_negative:          begin bsel = cmbse_pkg::SB_N; bpol = 1'b1; end
			cmbse_pkg::branch_positive:          begin bsel = cmbse_pkg::SB_N; bpol = 1'b0; end
			cmbse_pkg::branch_half_carry_one:    begin bsel = cmbse_pkg::SB_H; bpol = 1'b1; end
			cmbse_pkg::branch_half_carry_zero:   begin bsel = cmbse_pkg::SB_H; bpol = 1'b0; end
			cmbse_pkg::branch_transfer_flag_one: begin bsel = cmbse_pkg::SB_T; bpol = 1'b1; end
			cmbse_pkg::branch_transfer_flag_zero:begin bsel = cmbse_pkg::SB_T; bpol = 1'b0; end
			cmbse_pkg::branch_status_bit_zero:   begin bsel = i.bit_sel; bpol = 1'b0; end
			default:                             begin bsel = i.bit_sel; bpol = 1'b1; end
		endcase

		// Per-instruction effect and cost
		unique case (i.op)
			cmbse_pkg::test_zero_sign: begin
				r = i.rd_val & i.rd_val;
				wb.rd_we = 1'b1;
				wb.rd_wdata = r;
				f[cmbse_pkg::SB_Z] = (r == cmbse_pkg::BYTE_ZERO);
				f[cmbse_pkg::SB_N] = r[7];
				f[cmbse_pkg::SB_V] = 1'b0;
				f[cmbse_pkg::SB_S] = r[7];
			end
			cmbse_pkg::zero_register: begin
				r = i.rd_val ^ i.rd_val;
				wb.rd_we = 1'b1;
				wb.rd_wdata = r;
				f[cmbse_pkg::SB_Z] = (r == cmbse_pkg::BYTE_ZERO);
				f[cmbse_pkg::SB_N] = r[7];
				f[cmbse_pkg::SB_V] = 1'b0;
				f[cmbse_pkg::SB_S] = r[7];
			end
			cmbse_pkg::fill_ones_register: begin
				wb.rd_we = 1'b1;
				wb.rd_wdata = cmbse_pkg::BYTE_ONES;
			end
			cmbse_pkg::unsigned_product, cmbse_pkg::signed_product,
			cmbse_pkg::signed_by_unsigned_product: begin
				res16 = p16;
				wb.pair_we = 1'b1;
				wb.pair_wdata = res16;
				f[cmbse_pkg::SB_C] = p16[15];
				f[cmbse_pkg::SB_Z] = (res16 == 16'h0000);
				cost = cmbse_pkg::CYC_2;
			end
			cmbse_pkg::fractional_unsigned_product, cmbse_pkg::fractional_signed_product,
			cmbse_pkg::fractional_mixed_product: begin
				// shifted product, carry from the unshifted top bit
				res16 = {p16[14:0], 1'b0};
				wb.pair_we = 1'b1;
				wb.pair_wdata = res16;
				f[cmbse_pkg::SB_C] = p16[15];
				f[cmbse_pkg::SB_Z] = (res16 == 16'h0000);
				cost = cmbse_pkg::CYC_2;
			end
			cmbse_pkg::relative_jump: begin
				npc = rel;
				cost = cmbse_pkg::CYC_2;
			end
			cmbse_pkg::pointer_jump: begin
				npc = i.z_ptr;
				cost = cmbse_pkg::CYC_2;
			end
			cmbse_pkg::absolute_jump: begin
				npc = i.abs_addr;
				cost = cmbse_pkg::CYC_3;
			end
			cmbse_pkg::relative_subroutine_invoke: begin
				npc = rel;
				cost = cmbse_pkg::CYC_3;
				do_push = 1'b1;
			end
			cmbse_pkg::pointer_subroutine_invoke: begin
				npc = i.z_ptr;
				cost = cmbse_pkg::CYC_3;
				do_push = 1'b1;
			end
			cmbse_pkg::absolute_subroutine_invoke: begin
				// absolute call, two-word so return skips operand
				npc = i.abs_addr;
				cost = cmbse_pkg::CYC_4;
				rtn_addr = s_ff.pc + cmbse_pkg::STEP_2;
				do_push = 1'b1;
			end
			cmbse_pkg::subroutine_exit: begin
				do_pop = 1'b1;
				cost = cmbse_pkg::CYC_4;
			end
			cmbse_pkg::interrupt_handler_exit: begin
				do_pop = 1'b1;
				cost = cmbse_pkg::CYC_4;
				f[cmbse_pkg::SB_I] = 1'b1;
			end
			cmbse_pkg::compare_skip_equal: begin
				skip = (i.rd_val == i.rr_val);
			end
			cmbse_pkg::compare_regs, cmbse_pkg::compare_with_borrow,
			cmbse_pkg::compare_immediate: begin
				f[cmbse_pkg::SB_C] = diff[8];
				f[cmbse_pkg::SB_N] = r[7];
				f[cmbse_pkg::SB_V] = (i.rd_val[7] & ~sb[7] & ~r[7]) | (~i.rd_val[7] & sb[7] & r[7]);
				f[cmbse_pkg::SB_H] = (~i.rd_val[3] & sb[3]) | (sb[3] & r[3]) | (r[3] & ~i.rd_val[3]);
				f[cmbse_pkg::SB_S] = f[cmbse_pkg::SB_N] ^ f[cmbse_pkg::SB_V];
				// Borrow form only clears Z, so multi-byte compares chain
				f[cmbse_pkg::SB_Z] = (r == cmbse_pkg::BYTE_ZERO) &
					((i.op != cmbse_pkg::compare_with_borrow) | s_ff.status[cmbse_pkg::SB_Z]);
			end
			cmbse_pkg::skip_reg_bit_zero: skip = ~i.rr_val[i.bit_sel];
			cmbse_pkg::skip_reg_bit_one:  skip = i.rr_val[i.bit_sel];
			cmbse_pkg::skip_io_bit_zero:  skip = ~i.io_val[i.bit_sel];
			cmbse_pkg::skip_io_bit_one:   skip = i.io_val[i.bit_sel];
			cmbse_pkg::branch_signed_ge, cmbse_pkg::branch_signed_lt: begin
				take = ((s_ff.status[cmbse_pkg::SB_N] ^ s_ff.status[cmbse_pkg::SB_V]) ==
					(i.op == cmbse_pkg::branch_signed_lt));
			end
			default: begin
				take = (s_ff.status[bsel] == bpol);
			end
		endcase

		// taken branch redirects and costs two
		if (take) begin
			npc = rel;
			cost = cmbse_pkg::CYC_2;
		end

		// skip length follows the next instruction's size
		if (skip) begin
			npc = s_ff.pc + (i.next_two_word ? cmbse_pkg::STEP_3 : cmbse_pkg::STEP_2);
			cost = i.next_two_word ? cmbse_pkg::CYC_3 : cmbse_pkg::CYC_2;
		end

		unique case (s_ff.st)
			cmbse_pkg::ST_IDLE: begin
				// Outside flag loads only land between instructions
				if (status_wr) begin
					nxt_s.status = status_wdata;
				end
				if (issue) begin
					if (cost == cmbse_pkg::CYC_1) begin
						// Single-cycle ops commit on the issue edge
						nxt_s.pc     = npc;
						nxt_s.status = f;
						nxt_s.wb     = wb;
						nxt_s.done   = 1'b1;
					end else begin
						nxt_s.st          = cmbse_pkg::ST_RUN;
						nxt_s.busy        = 1'b1;
						nxt_s.cnt         = cost - cmbse_pkg::CYC_1;
						nxt_s.p_pc        = npc;
						nxt_s.p_status    = f;
						nxt_s.p_wb        = wb;
						nxt_s.p_push      = do_push;
						nxt_s.p_push_data = rtn_addr;
						nxt_s.pop         = do_pop;
					end
				end
			end
			cmbse_pkg::ST_RUN: begin
				// Return address arrives while pop is high
				if (s_ff.pop) begin
					nxt_s.p_pc = stack_data;
				end
				nxt_s.cnt = s_ff.cnt - cmbse_pkg::CYC_1;
				if (s_ff.cnt == cmbse_pkg::CYC_1) begin
					nxt_s.st        = cmbse_pkg::ST_IDLE;
					nxt_s.busy      = 1'b0;
					nxt_s.pc        = s_ff.pop ? stack_data : s_ff.p_pc;
					nxt_s.status    = s_ff.p_status;
					nxt_s.wb        = s_ff.p_wb;
					nxt_s.done      = 1'b1;
					nxt_s.push      = s_ff.p_push;
					nxt_s.push_data = s_ff.p_push_data;
				end
			end
		endcase
	end

	// State register; reset puts the core at the reset vector
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff        <= '0;
			s_ff.st     <= cmbse_pkg::ST_IDLE;
			s_ff.pc     <= cmbse_pkg::PC_RST;
			s_ff.status <= cmbse_pkg::STATUS_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register
	assign busy                  = s_ff.busy;
	assign done                  = s_ff.done;
	assign pc                    = s_ff.pc;
	assign status_flags_register = s_ff.status;
	assign rd_we                 = s_ff.wb.rd_we;
	assign rd_wdata              = s_ff.wb.rd_wdata;
	assign pair_we               = s_ff.wb.pair_we;
	assign pair_wdata            = s_ff.wb.pair_wdata;
	assign push                  = s_ff.push;
	assign push_data             = s_ff.push_data;
	assign pop                   = s_ff.pop;

endmodule

`default_nettype wire

// [cmbse_pkg.sv]
`default_nettype none

package cmbse_pkg;

	// Widths
	localparam int PC_W   = 16;
	localparam int DATA_W = 8;
	localparam int OFS_W  = 12;
	localparam int CYC_W  = 3;

	// Status flag positions
	localparam logic [2:0] SB_C = 3'h0;
	localparam logic [2:0] SB_Z = 3'h1;
	localparam logic [2:0] SB_N = 3'h2;
	localparam logic [2:0] SB_V = 3'h3;
	localparam logic [2:0] SB_S = 3'h4;
	localparam logic [2:0] SB_H = 3'h5;
	localparam logic [2:0] SB_T = 3'h6;
	localparam logic [2:0] SB_I = 3'h7;

	// Reset values
	localparam logic [7:0]  STATUS_RST = 8'h00;
	localparam logic [15:0] PC_RST     = 16'h0000;

	// Cycle costs
	localparam logic [CYC_W-1:0] CYC_1 = 3'h1;
	localparam logic [CYC_W-1:0] CYC_2 = 3'h2;
	localparam logic [CYC_W-1:0] CYC_3 = 3'h3;
	localparam logic [CYC_W-1:0] CYC_4 = 3'h4;

	// Program counter steps in words
	localparam logic [PC_W-1:0] STEP_1 = 16'h0001;
	localparam logic [PC_W-1:0] STEP_2 = 16'h0002;
	localparam logic [PC_W-1:0] STEP_3 = 16'h0003;

	// Data constants
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hFF;

	typedef enum logic [5:0] {
		test_zero_sign, zero_register, fill_ones_register,
		unsigned_product, signed_product, signed_by_unsigned_product,
		fractional_unsigned_product, fractional_signed_product, fractional_mixed_product,
		relative_jump, pointer_jump, absolute_jump,
		relative_subroutine_invoke, pointer_subroutine_invoke, absolute_subroutine_invoke,
		subroutine_exit, interrupt_handler_exit,
		compare_skip_equal, compare_regs, compare_with_borrow, compare_immediate,
		skip_reg_bit_zero, skip_reg_bit_one, skip_io_bit_zero, skip_io_bit_one,
		branch_status_bit_one, branch_status_bit_zero,
		branch_on_equal, branch_on_unequal, branch_carry_one, branch_carry_zero,
		branch_same_or_higher, branch_lower, branch_negative, branch_positive,
		branch_signed_ge, branch_signed_lt, branch_half_carry_one, branch_half_carry_zero,
		branch_transfer_flag_one, branch_transfer_flag_zero
	} cmbse_op_t;

	typedef struct packed {
		cmbse_op_t          op;
		logic [7:0]         rd_val;
		logic [7:0]         rr_val;
		logic [7:0]         imm;
		logic [2:0]         bit_sel;
		logic [OFS_W-1:0]   ofs;
		logic [PC_W-1:0]    abs_addr;
		logic [PC_W-1:0]    z_ptr;
		logic [7:0]         io_val;
		logic               next_two_word;
	} cmbse_issue_t;

	typedef struct packed {
		logic        rd_we;
		logic [7:0]  rd_wdata;
		logic        pair_we;
		logic [15:0] pair_wdata;
	} cmbse_wb_t;

	typedef enum logic {ST_IDLE, ST_RUN} cmbse_st_t;

	typedef struct packed {
		cmbse_st_t          st;
		logic [CYC_W-1:0]   cnt;
		logic [PC_W-1:0]    pc;
		logic [7:0]         status;
		logic [PC_W-1:0]    p_pc;
		logic [7:0]         p_status;
		cmbse_wb_t          p_wb;
		logic               p_push;
		logic [PC_W-1:0]    p_push_data;
		cmbse_wb_t          wb;
		logic               done;
		logic               push;
		logic [PC_W-1:0]    push_data;
		logic               pop;
		logic               busy;
	} cmbse_state_t;

endpackage

`default_nettype wire

// [cmbse_exec_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module cmbse_exec_sva (
	// Clock and reset
	input wire logic					mclk,
	input wire logic					arst_n,
	// Issue side
	input wire logic					issue,
	input wire cmbse_pkg::cmbse_issue_t	issue_data,
	input wire logic					status_wr,
	input wire logic [7:0]				status_wdata,
	input wire logic [15:0]				stack_data,
	// Results
	input wire logic					busy,
	input wire logic					done,
	input wire logic [15:0]				pc,
	input wire logic [7:0]				status_flags_register,
	input wire logic					rd_we,
	input wire logic [7:0]				rd_wdata,
	input wire logic					pair_we,
	input wire logic [15:0]				pair_wdata,
	input wire logic					push,
	input wire logic [15:0]				push_data,
	input wire logic					pop
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// Issue is only taken while idle
	logic					go;
	cmbse_pkg::cmbse_op_t	op;
	assign go = issue && !busy;
	assign op = issue_data.op;

	property p_return_pop;
		pop |-> busy ##3 (done && pc == $past(stack_data, 3));
	endproperty
	a_return_pop: assert property (p_return_pop) else $error("return target wrong");

	property p_push_return;
		push |-> done && (push_data == $past(pc) + 16'h0001 || push_data == $past(pc) + 16'h0002);
	endproperty
	a_push_return: assert property (p_push_return) else $error("pushed address wrong");

	property p_clear;
		go && op == cmbse_pkg::zero_register |=> done && rd_we && rd_wdata == 8'h00
			&& status_flags_register[3:1] == 3'h1;
	endproperty
	a_clear: assert property (p_clear) else $error("clear wrong");

	property p_test;
		go && op == cmbse_pkg::test_zero_sign |=> rd_we && rd_wdata == $past(issue_data.rd_val)
			&& status_flags_register[1] == ($past(issue_data.rd_val) == 8'h00);
	endproperty
	a_test: assert property (p_test) else $error("test wrong");

	property p_product;
		go && op == cmbse_pkg::unsigned_product |=> !done ##1 (pair_we && pair_wdata ==
			{8'h00, $past(issue_data.rd_val, 2)} * {8'h00, $past(issue_data.rr_val, 2)});
	endproperty
	a_product: assert property (p_product) else $error("product wrong");

	property p_frac_product;
		go && op == cmbse_pkg::fractional_unsigned_product |=> ##1 pair_wdata ==
			({8'h00, $past(issue_data.rd_val, 2)} * {8'h00, $past(issue_data.rr_val, 2)}) << 1;
	endproperty
	a_frac_product: assert property (p_frac_product) else $error("fractional product wrong");

	property p_pc_hold;
		$changed(pc) |-> done;
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved without commit");

	property p_taken;
		go && op == cmbse_pkg::branch_on_equal && status_flags_register[1] |=> busy ##1 (done
			&& pc == $past(pc) + {{4{$past(issue_data.ofs[11], 2)}}, $past(issue_data.ofs, 2)}
			+ 16'h0001);
	endproperty
	a_taken: assert property (p_taken) else $error("taken branch wrong");

	// Main scenarios seen
	c_return: cover property (pop);
	c_product: cover property (pair_we);
	c_call: cover property (push);
endmodule

bind cmbse_exec cmbse_exec_sva chk_u (
	.mclk(mclk), .arst_n(arst_n), .issue(issue), .issue_data(issue_data), .status_wr(status_wr),
	.status_wdata(status_wdata), .stack_data(stack_data), .busy(busy), .done(done), .pc(pc),
	.status_flags_register(status_flags_register), .rd_we(rd_we), .rd_wdata(rd_wdata),
	.pair_we(pair_we), .pair_wdata(pair_wdata), .push(push), .push_data(push_data), .pop(pop)
);

`default_nettype wire

// [cmbse_stack_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cmbse_stack_model (
	// Clock and reset
	input wire logic			mclk,
	input wire logic			arst_n,
	// Stack requests
	input wire logic			push,
	input wire logic [15:0]	push_data,
	input wire logic			pop,
	// Popped word
	output logic [15:0]		stack_data
);
	logic [15:0]	mem_ff [16];
	logic [3:0]		sp_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sp_ff <= 4'h0;
		end else if (push) begin
			mem_ff[sp_ff] <= push_data;
			sp_ff <= sp_ff + 4'h1;
		end else if (pop) begin
			sp_ff <= sp_ff - 4'h1;
		end
	end

	// Inverted outside pop so a late sample shows up
	assign stack_data = pop ? mem_ff[sp_ff - 4'h1] : ~mem_ff[sp_ff - 4'h1];
endmodule

`default_nettype wire

// [cpu_multiply_branch_skip_exec_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module cpu_multiply_branch_skip_exec_tb;
	logic						mclk = 1'b0;
	logic						arst_n = 1'b0;
	logic						issue = 1'b0;
	cmbse_pkg::cmbse_issue_t	idat = '0;
	logic						status_wr = 1'b0;
	logic [7:0]					status_wdata = 8'h00;
	logic [15:0]				stack_data, pc, pair_wdata, push_data;
	logic						busy, done, rd_we, pair_we, push, pop;
	logic [7:0]					flags, rd_wdata;
	logic [15:0]				epc = 16'h0000;
	logic [15:0]				stk [$];
	int							n_errors = 0;
	int							checks = 0;
	int							cyc = 0;
	int							t;

	cmbse_exec dut_u (
		.mclk(mclk), .arst_n(arst_n), .issue(issue), .issue_data(idat), .status_wr(status_wr),
		.status_wdata(status_wdata), .stack_data(stack_data), .busy(busy), .done(done), .pc(pc),
		.status_flags_register(flags), .rd_we(rd_we), .rd_wdata(rd_wdata), .pair_we(pair_we),
		.pair_wdata(pair_wdata), .push(push), .push_data(push_data), .pop(pop)
	);

	cmbse_stack_model stk_u (
		.mclk(mclk), .arst_n(arst_n), .push(push), .push_data(push_data), .pop(pop),
		.stack_data(stack_data)
	);

	always #5 mclk = ~mclk;

	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Cut a hang short well past the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// Load flags, issue one op, then compare cost and every result
	task automatic exec(input cmbse_pkg::cmbse_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic [2:0] s, input logic [11:0] k, input logic two, input logic [7:0] st);
		logic [15:0]	npc, tgt, r, pr;
		logic [8:0]		d;
		logic [4:0]		h;
		logic [7:0]		est;
		logic [2:0]		c;
		logic			tk, sk, rw, pv, ci, v, ml;
		int				n;
		tgt = epc + {{4{k[11]}}, k} + 16'h0001;
		{c, npc, r, est, tk, sk, rw, pv, pr} = {3'h1, epc + 16'h0001, 16'h0000, st, 4'h0, epc + 16'h0001};
		case (op)
			cmbse_pkg::test_zero_sign: {rw, r[7:0]} = {1'b1, a};
			cmbse_pkg::zero_register: rw = 1'b1;
			cmbse_pkg::fill_ones_register: {rw, r[7:0]} = {1'b1, 8'hFF};
			cmbse_pkg::unsigned_product, cmbse_pkg::fractional_unsigned_product:
				r = {8'h00, a} * {8'h00, b};
			cmbse_pkg::signed_product, cmbse_pkg::fractional_signed_product:
				r = {{8{a[7]}}, a} * {{8{b[7]}}, b};
			cmbse_pkg::signed_by_unsigned_product, cmbse_pkg::fractional_mixed_product:
				r = {{8{a[7]}}, a} * {8'h00, b};
			cmbse_pkg::relative_jump: {c, npc} = {3'h2, tgt};
			cmbse_pkg::pointer_jump: {c, npc} = {3'h2, a, b};
			cmbse_pkg::absolute_jump: {c, npc} = {3'h3, b, a};
			cmbse_pkg::relative_subroutine_invoke: {c, npc, pv} = {3'h3, tgt, 1'b1};
			cmbse_pkg::pointer_subroutine_invoke: {c, npc, pv} = {3'h3, a, b, 1'b1};
			cmbse_pkg::absolute_subroutine_invoke: {c, npc, pv, pr} = {3'h4, b, a, 1'b1, epc + 16'h0002};
			cmbse_pkg::subroutine_exit: {c, npc} = {3'h4, stk.pop_back()};
			cmbse_pkg::interrupt_handler_exit: {c, npc, est[7]} = {3'h4, stk.pop_back(), 1'b1};
			cmbse_pkg::compare_skip_equal: {sk, tk} = {1'b1, a == b};
			// Register tests read the second operand, I/O tests the port byte
			cmbse_pkg::skip_reg_bit_zero: {sk, tk} = {1'b1, !b[s]};
			cmbse_pkg::skip_reg_bit_one: {sk, tk} = {1'b1, b[s]};
			cmbse_pkg::skip_io_bit_zero: {sk, tk} = {1'b1, !a[s]};
			cmbse_pkg::skip_io_bit_one: {sk, tk} = {1'b1, a[s]};
			cmbse_pkg::branch_status_bit_one: tk = st[s];
			cmbse_pkg::branch_status_bit_zero: tk = !st[s];
			cmbse_pkg::branch_on_equal: tk = st[1];
			cmbse_pkg::branch_on_unequal: tk = !st[1];
			cmbse_pkg::branch_carry_one, cmbse_pkg::branch_lower: tk = st[0];
			cmbse_pkg::branch_carry_zero, cmbse_pkg::branch_same_or_higher: tk = !st[0];
			cmbse_pkg::branch_negative: tk = st[2];
			cmbse_pkg::branch_positive: tk = !st[2];
			cmbse_pkg::branch_signed_ge: tk = !(st[2] ^ st[3]);
			cmbse_pkg::branch_signed_lt: tk = st[2] ^ st[3];
			cmbse_pkg::branch_half_carry_one: tk = st[5];
			cmbse_pkg::branch_half_carry_zero: tk = !st[5];
			cmbse_pkg::branch_transfer_flag_one: tk = st[6];
			cmbse_pkg::branch_transfer_flag_zero: tk = !st[6];
			default: ;
		endcase
		// Test and clear flags follow the byte written back
		if (rw && op != cmbse_pkg::fill_ones_register) est[4:1] = {r[7], 1'b0, r[7], r[7:0] == 8'h00};
		// Carry comes from the top bit before the fractional shift
		ml = op inside {[cmbse_pkg::unsigned_product:cmbse_pkg::fractional_mixed_product]};
		if (ml) est[0] = r[15];
		if (ml) r = (op >= cmbse_pkg::fractional_unsigned_product) ? r << 1 : r;
		if (ml) {c, est[1]} = {3'h2, r == 16'h0000};
		// Compares: result dropped, zero chains through the borrow form
		ci = op == cmbse_pkg::compare_with_borrow && st[0];
		d = {1'b0, a} - {1'b0, b} - {8'h00, ci};
		h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
		v = (a[7] ^ b[7]) & (a[7] ^ d[7]);
		if (op inside {[cmbse_pkg::compare_regs:cmbse_pkg::compare_immediate]})
			est[5:0] = {h[4], d[7] ^ v, v, d[7],
				d[7:0] == 8'h00 && (op != cmbse_pkg::compare_with_borrow || st[1]), d[8]};
		if (sk && tk) {c, npc} = {two ? 3'h3 : 3'h2, epc + (two ? 16'h0003 : 16'h0002)};
		if (op >= cmbse_pkg::branch_status_bit_one && tk) {c, npc} = {3'h2, tgt};
		@(posedge mclk);
		status_wr <= 1'b1;
		status_wdata <= st;
		@(posedge mclk);
		status_wr <= 1'b0;
		issue <= 1'b1;
		idat <= '{op, a, b, b, s, k, {b, a}, {a, b}, a, two};
		@(posedge mclk);
		issue <= 1'b0;
		#1;
		n = 1;
		while (done !== 1'b1 && n < 6) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(n == int'(c), "cycle count");
		chk(pc === npc, "program counter");
		chk(flags === est, "flags");
		chk(rd_we === rw && (!rw || rd_wdata === r[7:0]), "register write");
		chk(pair_we === ml && (!ml || pair_wdata === r), "product");
		chk(push === pv && (!pv || push_data === pr), "push");
		if (pv) stk.push_back(pr);
		epc = npc;
	endtask

	// Random operands; returns need a stacked address, and the stack stays shallow
	task automatic rnd(input int i);
		cmbse_pkg::cmbse_op_t op;
		op = cmbse_pkg::cmbse_op_t'(i);
		if (op inside {cmbse_pkg::subroutine_exit, cmbse_pkg::interrupt_handler_exit} && stk.size() == 0)
			op = cmbse_pkg::relative_subroutine_invoke;
		if (op inside {[cmbse_pkg::relative_subroutine_invoke:cmbse_pkg::absolute_subroutine_invoke]}
			&& stk.size() > 14) op = cmbse_pkg::fill_ones_register;
		exec(op, 8'($urandom), 8'($urandom), 3'($urandom), 12'($urandom), 1'($urandom), 8'($urandom));
	endtask

	initial begin
		t = $urandom(32'h0d1d18ed);
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		// Every operation once
		for (int i = 0; i < 41; i++) begin
			rnd(i);
		end
		// Corner values
		exec(cmbse_pkg::signed_product, 8'h80, 8'h80, 3'h0, 12'h000, 1'b0, 8'h00);
		exec(cmbse_pkg::fractional_signed_product, 8'h80, 8'h80, 3'h0, 12'h000, 1'b0, 8'h00);
		exec(cmbse_pkg::fractional_unsigned_product, 8'hFF, 8'hFF, 3'h0, 12'h000, 1'b0, 8'h00);
		exec(cmbse_pkg::compare_with_borrow, 8'h05, 8'h04, 3'h0, 12'h000, 1'b0, 8'h01);
		exec(cmbse_pkg::compare_skip_equal, 8'h3C, 8'h3C, 3'h0, 12'h000, 1'b1, 8'h00);
		exec(cmbse_pkg::branch_on_equal, 8'h00, 8'h00, 3'h0, 12'h800, 1'b0, 8'h02);
		exec(cmbse_pkg::branch_on_unequal, 8'h00, 8'h00, 3'h0, 12'h7FF, 1'b0, 8'h02);
		for (int i = 0; i < 300; i++) begin
			rnd(int'($urandom % 41));
		end
		end_of_test();
	end
endmodule

`default_nettype wire
